// ---- pkg/sgc_pkg.sv ----
package sgc_pkg;
    localparam int CLK_HZ   = 20_000_000;
    localparam int TICK_US  = 1000;
    localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    localparam int DO_OP_MS = 5;
    localparam int NDI      = 8;
    localparam int NRT      = 4;
    localparam int NDO      = NRT + 2;
    localparam int NREC     = 12;
    localparam int DLY_W    = 21;
    localparam int TB_W     = 16;
    localparam int EV_W     = 8;
    localparam int REC_W    = 19;
    localparam int AW       = 7;

    localparam logic [AW-1:0] A_CTRL   = 7'h00;
    localparam logic [AW-1:0] A_TRAV   = 7'h04;
    localparam logic [AW-1:0] A_PLEN   = 7'h08;
    localparam logic [AW-1:0] A_TERM   = 7'h0C;
    localparam logic [AW-1:0] A_SEL    = 7'h10;
    localparam logic [AW-1:0] A_DIPOL  = 7'h14;
    localparam logic [AW-1:0] A_DOPOL  = 7'h18;
    localparam logic [AW-1:0] A_EVMASK = 7'h1C;
    localparam logic [AW-1:0] A_ROUTE  = 7'h20;
    localparam logic [AW-1:0] A_STATUS = 7'h24;
    localparam logic [AW-1:0] A_STATS  = 7'h28;
    localparam logic [AW-1:0] A_RECIDX = 7'h2C;
    localparam logic [AW-1:0] A_RECDAT = 7'h30;
    localparam logic [AW-1:0] A_DLY    = 7'h40;

    localparam int CB_REMOTE  = 0;
    localparam int CB_USE_RDY = 1;
    localparam int CB_USE_SYN = 2;
    localparam int CB_OPEN    = 3;
    localparam int CB_CLOSE   = 4;
    localparam int CB_CLR_REC = 5;
    localparam int CB_LCLR    = 6;

    localparam int SF_LO_OPEN  = 0;
    localparam int SF_LO_CLOSE = 4;
    localparam int SF_RE_OPEN  = 8;
    localparam int SF_RE_CLOSE = 12;
    localparam int SF_BLK      = 16;
    localparam int SF_BLK_EN   = 21;

    localparam int DI_FB_OPEN   = 0;
    localparam int DI_FB_CLOSED = 1;
    localparam int DI_READY     = 2;
    localparam int DI_SYNC      = 3;

    localparam logic [15:0] TRAV_RST   = 16'h0064;
    localparam logic [15:0] PLEN_RST   = 16'h00C8;
    localparam logic [15:0] TERM_RST   = 16'h01F4;
    localparam logic [31:0] SEL_RST    = 32'h0000_7654;
    localparam logic [7:0]  DIPOL_RST  = 8'h00;
    localparam logic [5:0]  DOPOL_RST  = 6'h00;
    localparam logic [7:0]  EVMASK_RST = 8'h00;

    localparam logic [1:0] OBJ_INTER  = 2'h0;
    localparam logic [1:0] OBJ_OPEN   = 2'h1;
    localparam logic [1:0] OBJ_CLOSED = 2'h2;
    localparam logic [1:0] OBJ_BAD    = 2'h3;

    localparam int EV_OPEN_REQ   = 0;
    localparam int EV_CLOSE_REQ  = 1;
    localparam int EV_OPEN_FAIL  = 2;
    localparam int EV_CLOSE_FAIL = 3;
    localparam int EV_ST_BASE    = 4;

    typedef enum logic [1:0] {CS_IDLE, CS_PULSE, CS_WAIT} sgc_ctl_e;
endpackage

// ---- pkg/sgc_io_if.sv ----
`timescale 1ns/1ns
interface sgc_io_if;
    logic                                        tick;
    logic [sgc_pkg::NDI-1:0]                     di_pol;
    logic [sgc_pkg::NDI-1:0]                     di_q;
    logic [sgc_pkg::NDI-1:0][sgc_pkg::DLY_W-1:0] act;
    logic [sgc_pkg::NDI-1:0][sgc_pkg::DLY_W-1:0] rel;
    logic [3:0]                                  st_hot;
    logic [15:0]                                 rt_cfg;
    logic                                        lclr;
    logic [sgc_pkg::NRT-1:0]                     rt_out;
    modport ctl(output tick, di_pol, act, rel, st_hot, rt_cfg, lclr, input di_q, rt_out);
    modport din(input tick, di_pol, act, rel, output di_q);
    modport rte(input st_hot, rt_cfg, lclr, output rt_out);
endinterface

// ---- core/sgc_din.sv ----
`timescale 1ns/1ns
module sgc_din (
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire logic [sgc_pkg::NDI-1:0]  di_pin,
    sgc_io_if.din                         io
);
    typedef struct packed {
        logic [sgc_pkg::NDI-1:0]                     s1;
        logic [sgc_pkg::NDI-1:0]                     s2;
        logic [sgc_pkg::NDI-1:0]                     q;
        logic [sgc_pkg::NDI-1:0][sgc_pkg::DLY_W-1:0] cnt;
    } sgc_din_s;
    sgc_din_s r_q, r_d;
    logic a;
    always_comb begin
        r_d = r_q;
        a = 1'h0;
        r_d.s1 = di_pin;
        r_d.s2 = r_q.s1;
        for (int i = 0; i < sgc_pkg::NDI; i++) begin
            a = r_q.s2[i] ^ io.di_pol[i];
            if (a == r_q.q[i]) begin
                r_d.cnt[i] = '0;
            end else if (r_q.cnt[i] >= (a ? io.act[i] : io.rel[i])) begin
                r_d.q[i] = a;
                r_d.cnt[i] = '0;
            end else if (io.tick) begin
                r_d.cnt[i] = r_q.cnt[i] + 1'h1;
            end
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end
    assign io.di_q = r_q.q;
endmodule // sgc_din

// ---- core/sgc_route.sv ----
`timescale 1ns/1ns
module sgc_route (
    input  wire logic mclk,
    input  wire logic rst,
    sgc_io_if.rte     io
);
    typedef struct packed {
        logic [sgc_pkg::NRT-1:0] lat;
        logic [sgc_pkg::NRT-1:0] out;
    } sgc_rte_s;
    sgc_rte_s r_q, r_d;
    logic src;
    always_comb begin
        r_d = r_q;
        src = 1'h0;
        for (int k = 0; k < sgc_pkg::NRT; k++) begin
            src = io.st_hot[io.rt_cfg[4*k +: 2]] & io.rt_cfg[4*k+2];
            // set wins, clear only once low
            r_d.lat[k] = src | (r_q.lat[k] & ~io.lclr);
            r_d.out[k] = io.rt_cfg[4*k+3] ? r_d.lat[k] : src;
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end
    assign io.rt_out = r_q.out;
endmodule // sgc_route

// ---- core/sgc_top.sv ----
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
module sgc_top #(
    parameter int unsigned MS_CYCLES = sgc_pkg::TICK_CYC
) (
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire logic [sgc_pkg::AW-1:0]   avs_address,
    input  wire logic                     avs_read,
    input  wire logic                     avs_write,
    input  wire logic [31:0]              avs_writedata,
    input  wire logic [3:0]               avs_byteenable,
    output logic      [31:0]              avs_readdata,
    output logic                          avs_waitrequest,
    input  wire logic [sgc_pkg::NDI-1:0]  di_pin,
    input  wire logic [7:0]               logic_in,
    input  wire logic [11:0]              stage_sig,
    input  wire logic                     app_open,
    input  wire logic                     app_close,
    output logic      [sgc_pkg::NDO-1:0]  do_pin,
    output logic                          evt_stb,
    output logic      [sgc_pkg::EV_W-1:0] evt_code
);
    typedef struct packed {
        logic                                        ack;
        logic [31:0]                                 rdata;
        logic                                        remote;
        logic                                        use_rdy;
        logic                                        use_syn;
        logic [15:0]                                 trav;
        logic [15:0]                                 plen;
        logic [15:0]                                 term;
        logic [31:0]                                 sel;
        logic [7:0]                                  dipol;
        logic [5:0]                                  dopol;
        logic [7:0]                                  evmask;
        logic [15:0]                                 route;
        logic [3:0]                                  recidx;
        logic [sgc_pkg::NDI-1:0][sgc_pkg::DLY_W-1:0] act;
        logic [sgc_pkg::NDI-1:0][sgc_pkg::DLY_W-1:0] rel;
        logic [sgc_pkg::TB_W-1:0]                    ms_cnt;
        logic                                        tick;
        logic [1:0]                                  status;
        logic [15:0]                                 gap;
        sgc_pkg::sgc_ctl_e                           st;
        logic                                        is_close;
        logic [15:0]                                 pcnt;
        logic [16:0]                                 tcnt;
        logic                                        cmd_o;
        logic                                        cmd_c;
        logic [1:0]                                  app_prev;
        logic [7:0]                                  qprev;
        logic                                        lclr;
        logic [3:0][7:0]                             stats;
        logic [sgc_pkg::NREC-1:0][sgc_pkg::REC_W-1:0] rec;
        logic [3:0]                                  wptr;
        logic                                        last_fail;
        logic                                        evt_stb;
        logic [7:0]                                  evt_code;
        logic [5:0]                                  do_q;
    } sgc_top_s;

    sgc_top_s r_q, r_d;
    sgc_io_if io ();

    sgc_din u_din (
        .mclk   (mclk),
        .rst    (rst),
        .di_pin (di_pin),
        .io     (io.din)
    );

    sgc_route u_route (
        .mclk (mclk),
        .rst  (rst),
        .io   (io.rte)
    );

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                m[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return m;
    endfunction

    logic        req;
    logic [31:0] w;
    logic [31:0] rd;
    logic        bus_o;
    logic        bus_c;
    logic        clr;
    logic        rq_o;
    logic        rq_c;
    logic        fo;
    logic        fc;
    logic        blocked;
    logic        permit;
    logic        reached;
    logic        tmo;
    logic        done;
    logic        fail;
    logic        cls;
    logic [7:0]  de;
    logic [7:0]  ev;
    logic [31:0] blk_src;
    logic [2:0]  dix;

    assign req = avs_read | avs_write;
    assign fo = io.di_q[sgc_pkg::DI_FB_OPEN];
    assign fc = io.di_q[sgc_pkg::DI_FB_CLOSED];
    assign blk_src = {stage_sig, io.st_hot, logic_in, io.di_q};

    always_comb begin
        r_d = r_q;
        w = '0;
        rd = '0;
        bus_o = 1'h0;
        bus_c = 1'h0;
        clr = 1'h0;
        rq_o = 1'h0;
        rq_c = 1'h0;
        done = 1'h0;
        fail = 1'h0;
        cls = r_q.is_close;
        ev = '0;
        dix = '0;
        r_d.lclr = 1'h0;

        // 1 ms timebase shared by the input filter, gap, pulse and timeout counters
        if (r_q.ms_cnt == sgc_pkg::TB_W'(MS_CYCLES - 1)) begin
            r_d.ms_cnt = '0;
            r_d.tick = 1'h1;
        end else begin
            r_d.ms_cnt = r_q.ms_cnt + 1'h1;
            r_d.tick = 1'h0;
        end

        // bus: answer on second edge, read data captured on first
        r_d.ack = req & ~r_q.ack;
        case (avs_address)
            sgc_pkg::A_CTRL:   rd = {29'h0, r_q.use_syn, r_q.use_rdy, r_q.remote};
            sgc_pkg::A_TRAV:   rd = {16'h0, r_q.trav};
            sgc_pkg::A_PLEN:   rd = {16'h0, r_q.plen};
            sgc_pkg::A_TERM:   rd = {16'h0, r_q.term};
            sgc_pkg::A_SEL:    rd = {10'h0, r_q.sel[21:0]};
            sgc_pkg::A_DIPOL:  rd = {24'h0, r_q.dipol};
            sgc_pkg::A_DOPOL:  rd = {26'h0, r_q.dopol};
            sgc_pkg::A_EVMASK: rd = {24'h0, r_q.evmask};
            sgc_pkg::A_ROUTE:  rd = {16'h0, r_q.route};
            sgc_pkg::A_STATUS: rd = {4'h0, r_q.wptr, io.di_q, 4'h0, io.rt_out,
                                     2'h0, r_q.last_fail, blocked, r_q.st, r_q.status};
            sgc_pkg::A_STATS:  rd = r_q.stats;
            sgc_pkg::A_RECIDX: rd = {28'h0, r_q.recidx};
            sgc_pkg::A_RECDAT: rd = (r_q.recidx < 4'(sgc_pkg::NREC)) ?
                                    {13'h0, r_q.rec[r_q.recidx]} : '0;
            default: begin
                if (avs_address[6] && avs_address[1:0] == 2'h0) begin
                    rd = {11'h0, avs_address[2] ? r_q.rel[avs_address[5:3]]
                                                : r_q.act[avs_address[5:3]]};
                end
            end
        endcase
        if (req && !r_q.ack) begin
            r_d.rdata = rd;
        end
        if (avs_write && r_q.ack) begin
            w = merge(rd, avs_writedata, avs_byteenable);
            case (avs_address)
                sgc_pkg::A_CTRL: begin
                    r_d.remote = w[sgc_pkg::CB_REMOTE];
                    r_d.use_rdy = w[sgc_pkg::CB_USE_RDY];
                    r_d.use_syn = w[sgc_pkg::CB_USE_SYN];
                    bus_o = w[sgc_pkg::CB_OPEN];
                    bus_c = w[sgc_pkg::CB_CLOSE];
                    clr = w[sgc_pkg::CB_CLR_REC];
                    r_d.lclr = w[sgc_pkg::CB_LCLR];
                end
                sgc_pkg::A_TRAV:   r_d.trav = w[15:0];
                sgc_pkg::A_PLEN:   r_d.plen = w[15:0];
                sgc_pkg::A_TERM:   r_d.term = w[15:0];
                sgc_pkg::A_SEL:    r_d.sel = {10'h0, w[21:0]};
                sgc_pkg::A_DIPOL:  r_d.dipol = w[7:0];
                sgc_pkg::A_DOPOL:  r_d.dopol = w[5:0];
                sgc_pkg::A_EVMASK: r_d.evmask = w[7:0];
                sgc_pkg::A_ROUTE:  r_d.route = w[15:0];
                sgc_pkg::A_RECIDX: r_d.recidx = w[3:0];
                default: begin
                    if (avs_address[6] && avs_address[1:0] == 2'h0) begin
                        if (avs_address[2]) begin
                            r_d.rel[avs_address[5:3]] = w[sgc_pkg::DLY_W-1:0];
                        end else begin
                            r_d.act[avs_address[5:3]] = w[sgc_pkg::DLY_W-1:0];
                        end
                    end
                end
            endcase
        end

        case ({fo, fc})
            2'h2: begin
                r_d.status = sgc_pkg::OBJ_OPEN;
                r_d.gap = '0;
            end
            2'h1: begin
                r_d.status = sgc_pkg::OBJ_CLOSED;
                r_d.gap = '0;
            end
            2'h3: begin
                r_d.status = sgc_pkg::OBJ_BAD;
                r_d.gap = '0;
            end
            default: begin
                if (r_q.gap > r_q.trav) begin
                    r_d.status = sgc_pkg::OBJ_INTER;
                end else if (r_q.tick) begin
                    r_d.gap = r_q.gap + 1'h1;
                end
            end
        endcase
        if (r_d.status != r_q.status) begin
            ev[sgc_pkg::EV_ST_BASE + int'(r_d.status)] = 1'h1;
        end

        // request paths
        de = io.di_q & ~r_q.qprev;
        r_d.qprev = io.di_q;
        r_d.app_prev = {app_close, app_open};
        if (r_q.remote) begin
            dix = r_q.sel[sgc_pkg::SF_RE_OPEN +: 3];
            rq_o = bus_o | de[dix];
            dix = r_q.sel[sgc_pkg::SF_RE_CLOSE +: 3];
            rq_c = bus_c | de[dix];
        end else begin
            dix = r_q.sel[sgc_pkg::SF_LO_OPEN +: 3];
            rq_o = de[dix];
            dix = r_q.sel[sgc_pkg::SF_LO_CLOSE +: 3];
            rq_c = de[dix];
        end
        rq_o = rq_o | (app_open & ~r_q.app_prev[0]);
        rq_c = rq_c | (app_close & ~r_q.app_prev[1]);

        reached = r_q.is_close ? (r_q.status == sgc_pkg::OBJ_CLOSED)
                               : (r_q.status == sgc_pkg::OBJ_OPEN);
        tmo = r_q.tcnt >= (17'(r_q.term) + 17'(sgc_pkg::DO_OP_MS));
        if (r_q.tick) begin
            r_d.pcnt = r_q.pcnt + 1'h1;
            r_d.tcnt = r_q.tcnt + 1'h1;
        end

        case (r_q.st)
            sgc_pkg::CS_IDLE: begin
                // open wins over a simultaneous close
                if (rq_o || rq_c) begin
                    cls = ~rq_o;
                    r_d.is_close = cls;
                    r_d.pcnt = '0;
                    r_d.tcnt = '0;
                    r_d.stats[int'(cls)] = r_q.stats[int'(cls)] + 1'h1;
                    ev[sgc_pkg::EV_OPEN_REQ + int'(cls)] = 1'h1;
                    if (blocked || (cls && !permit)) begin
                        done = 1'h1;
                        fail = 1'h1;
                    end else begin
                        r_d.st = sgc_pkg::CS_PULSE;
                        r_d.cmd_o = ~cls;
                        r_d.cmd_c = cls;
                    end
                end
            end
            sgc_pkg::CS_PULSE, sgc_pkg::CS_WAIT: begin
                if (reached) begin
                    done = 1'h1;
                end else if (tmo) begin
                    done = 1'h1;
                    fail = 1'h1;
                end else if (r_q.pcnt >= r_q.plen) begin
                    r_d.st = sgc_pkg::CS_WAIT;
                    r_d.cmd_o = 1'h0;
                    r_d.cmd_c = 1'h0;
                end
                if (done) begin
                    r_d.st = sgc_pkg::CS_IDLE;
                    r_d.cmd_o = 1'h0;
                    r_d.cmd_c = 1'h0;
                end
            end
            default: begin
                r_d.st = sgc_pkg::CS_IDLE;
                r_d.cmd_o = 1'h0;
                r_d.cmd_c = 1'h0;
            end
        endcase

        if (done) begin
            r_d.rec[r_q.wptr] = {1'h1, fail, cls, r_d.tcnt[15:0]};
            r_d.wptr = (r_q.wptr == 4'(sgc_pkg::NREC - 1)) ? 4'h0 : r_q.wptr + 4'h1;
            r_d.last_fail = fail;
            if (fail) begin
                r_d.stats[2 + int'(cls)] = r_q.stats[2 + int'(cls)] + 1'h1;
                ev[sgc_pkg::EV_OPEN_FAIL + int'(cls)] = 1'h1;
            end
        end
        if (clr) begin
            r_d.rec = '0;
            r_d.wptr = '0;
            r_d.stats = '0;
            r_d.last_fail = 1'h0;
        end

        r_d.evt_code = ev & r_q.evmask;
        r_d.evt_stb = |(ev & r_q.evmask);
        r_d.do_q = {io.rt_out, r_d.cmd_c, r_d.cmd_o} ^ r_q.dopol;
    end

    assign blocked = r_q.sel[sgc_pkg::SF_BLK_EN] & blk_src[r_q.sel[sgc_pkg::SF_BLK +: 5]];
    assign permit = (~r_q.use_rdy | io.di_q[sgc_pkg::DI_READY])
                  & (~r_q.use_syn | io.di_q[sgc_pkg::DI_SYNC]);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r_q <= '0;
            r_q.trav <= sgc_pkg::TRAV_RST;
            r_q.plen <= sgc_pkg::PLEN_RST;
            r_q.term <= sgc_pkg::TERM_RST;
            r_q.sel <= sgc_pkg::SEL_RST;
            r_q.dipol <= sgc_pkg::DIPOL_RST;
            r_q.dopol <= sgc_pkg::DOPOL_RST;
            r_q.evmask <= sgc_pkg::EVMASK_RST;
            r_q.st <= sgc_pkg::CS_IDLE;
        end else begin
            r_q <= r_d;
        end
    end

    assign io.tick = r_q.tick;
    assign io.di_pol = r_q.dipol;
    assign io.act = r_q.act;
    assign io.rel = r_q.rel;
    assign io.st_hot = 4'h1 << r_q.status;
    assign io.rt_cfg = r_q.route;
    assign io.lclr = r_q.lclr;

    assign avs_readdata = r_q.rdata;
    assign avs_waitrequest = req & ~r_q.ack;
    assign do_pin = r_q.do_q;
    assign evt_stb = r_q.evt_stb;
    assign evt_code = r_q.evt_code;
endmodule // sgc_top

// ---- verif/sgc_chk.sv ----
`timescale 1ns/1ns
module sgc_chk #(
    parameter int unsigned MS_CYCLES = sgc_pkg::TICK_CYC
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [5:0]  do_pin,
    input wire logic        evt_stb,
    input wire logic [7:0]  evt_code
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // wide enough for the full-speed tick without wrapping
    logic [31:0] len_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) len_q <= '0;
        else len_q <= do_pin[0] ? len_q + 32'h0000_0001 : 32'h0000_0000;
    end
    chk_wait_two: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read not answered on second edge");
    chk_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest without request");
    chk_reset_quiet: assert property ($fell(rst) |-> avs_readdata == 32'h0 && do_pin == 6'h00)
        else $error("outputs not quiet after reset");
    chk_evt_clean: assert property (!evt_stb |-> evt_code == 8'h00)
        else $error("event code without strobe");
    chk_evt_code: assert property (evt_stb |-> evt_code != 8'h00)
        else $error("strobe without event code");
    chk_cmd_excl: assert property (!(do_pin[0] && do_pin[1]))
        else $error("open and close together");
    chk_cmd_len: assert property (int'(len_q) <= 202 * MS_CYCLES)
        else $error("open pulse too long");
    chk_cmd_min: assert property ($rose(do_pin[0]) |=> do_pin[0])
        else $error("open pulse one cycle only");
    cover property ($rose(do_pin[0]));
    cover property ($rose(do_pin[1]));
    cover property (evt_stb);
endmodule // sgc_chk
bind sgc_top sgc_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.mclk(mclk), .rst(rst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .do_pin(do_pin), .evt_stb(evt_stb), .evt_code(evt_code));

// ---- verif/sgc_brk.sv ----
`timescale 1ns/1ns
module sgc_brk #(
    parameter int DLY = 40
) (
    input  wire logic       mclk,
    input  wire logic       cmd_open,
    input  wire logic       cmd_close,
    input  wire logic       stuck,
    output logic      [1:0] fb
);
    logic [7:0] n = 8'h00;
    initial fb = 2'b10;
    always @(posedge mclk) begin
        if (stuck || cmd_open == cmd_close) n <= 8'h00;
        else begin
            n <= n + 8'h01;
            if (n == 8'h01) fb <= 2'b00;
            if (n == 8'(DLY)) fb <= cmd_open ? 2'b01 : 2'b10;
        end
    end
endmodule // sgc_brk

// ---- verif/tb_switchgear_object_control.sv ----
`timescale 1ns/1ns
module tb_switchgear_object_control;
    logic mclk = 0, rst = 1, rd_e = 0, wr_e = 0, a_o = 0, a_c = 0, stuck = 0;
    logic [6:0] adr = 0;
    logic [31:0] wd = 0, rdata;
    logic [7:0] lin = 0, evt_code, ev_acc = 0;
    logic [5:0] do_pin;
    logic [1:0] fb;
    logic waitreq, evt_stb;
    int error_cnt = 0, tests_run = 0, cyc = 0;
    always #25 mclk = ~mclk;
    sgc_top #(.MS_CYCLES(20)) DUT (.mclk(mclk), .rst(rst), .avs_address(adr), .avs_read(rd_e),
        .avs_write(wr_e), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdata),
        .avs_waitrequest(waitreq), .di_pin({4'h0, 2'h3, fb}), .logic_in(lin), .stage_sig(12'h000),
        .app_open(a_o), .app_close(a_c), .do_pin(do_pin), .evt_stb(evt_stb), .evt_code(evt_code));
    sgc_brk u_brk (.mclk(mclk), .cmd_open(do_pin[0]), .cmd_close(do_pin[1]), .stuck(stuck), .fb(fb));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(posedge mclk);
        adr <= a;
        wd <= d;
        wr_e <= 1'b1;
        @(posedge mclk iff !waitreq);
        wr_e <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [31:0] exp, input logic [31:0] m);
        @(posedge mclk);
        adr <= a;
        rd_e <= 1'b1;
        @(posedge mclk iff !waitreq);
        rd_e <= 1'b0;
        cmp(rdata & m, exp);
    endtask
    task automatic app(input logic cl);
        @(posedge mclk);
        a_o <= !cl;
        a_c <= cl;
        @(posedge mclk);
        a_o <= 1'b0;
        a_c <= 1'b0;
    endtask
    task automatic hold(input int b, input logic v, input int n);
        for (int i = 0; i < n && do_pin[b] !== v; i++) @(posedge mclk);
        cmp(32'(do_pin[b]), 32'(v));
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // one-cycle event strobes gathered so tests can look later
    always @(posedge mclk) begin
        if (evt_stb === 1'b1) ev_acc <= ev_acc | evt_code;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rd(7'h00, 32'h0, 32'hFFFFFFFF);
        rd(7'h04, 32'h64, 32'hFFFFFFFF);
        rd(7'h10, 32'h7654, 32'hFFFFFFFF);
        rd(7'h1C, 32'h0, 32'hFFFFFFFF);
        rd(7'h7C, 32'h0, 32'hFFFFFFFF);
        cmp(32'(ev_acc), 32'h0);
        $display("test defaults done");
        wr(7'h1C, 32'hFF);
        wr(7'h00, 32'h08);
        repeat (50) @(posedge mclk);
        cmp(32'(do_pin), 32'h0);
        // remote has to stand before the bus request is taken
        wr(7'h00, 32'h01);
        wr(7'h00, 32'h09);
        hold(0, 1'b1, 10);
        hold(0, 1'b0, 200);
        rd(7'h24, 32'h1, 32'h3);
        cmp(32'(ev_acc), 32'h21);
        $display("test bus open done");
        wr(7'h00, 32'h0);
        app(1'b1);
        hold(1, 1'b1, 10);
        hold(1, 1'b0, 200);
        rd(7'h24, 32'h2, 32'h3);
        $display("test app close done");
        lin <= 8'h01;
        wr(7'h10, 32'h0028_7654);
        app(1'b0);
        repeat (100) @(posedge mclk);
        cmp(32'(do_pin), 32'h0);
        $display("test block done");
        lin <= 8'h00;
        stuck <= 1'b1;
        wr(7'h08, 32'h0A);
        wr(7'h0C, 32'h14);
        app(1'b0);
        hold(0, 1'b1, 10);
        hold(0, 1'b0, 260);
        repeat (700) @(posedge mclk);
        rd(7'h28, 32'h0002_0103, 32'hFFFFFFFF);
        cmp(32'(ev_acc), 32'h67);
        wr(7'h00, 32'h20);
        rd(7'h28, 32'h0, 32'hFFFFFFFF);
        rd(7'h30, 32'h0, 32'h0004_0000);
        $display("test timeout and clear done");
        wr(7'h20, 32'h7F);
        wr(7'h14, 32'h01);
        repeat (10) @(posedge mclk);
        rd(7'h24, 32'h3, 32'h3);
        cmp(32'(do_pin), 32'h0C);
        wr(7'h04, 32'h02);
        wr(7'h14, 32'h02);
        rd(7'h24, 32'h3, 32'h3);
        repeat (100) @(posedge mclk);
        rd(7'h24, 32'h0, 32'h3);
        cmp(32'(do_pin), 32'h04);
        wr(7'h00, 32'h40);
        repeat (5) @(posedge mclk);
        cmp(32'(do_pin), 32'h0);
        wr(7'h18, 32'h30);
        repeat (5) @(posedge mclk);
        cmp(32'(do_pin), 32'h30);
        cmp(32'(ev_acc), 32'hF7);
        $display("test polarity and routing done");
        conclude();
    end
endmodule // tb_switchgear_object_control
